// [inc/vrc_pkg.sv]
// shared constants and types for the video-dram refresh and access-start block
package vrc_pkg;
  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50; // 20 MHz core clock
  localparam int ROW_STROBE_MIN_NS = 120;
  // least time rounds up to whole cycles
  localparam int REFRESH_SEQ_CYCLES = (ROW_STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INSTR_SEQ_STAGES = 4;
  localparam int DATA_SEQ_STAGES = 4;
  localparam int REFRESH_INTERVAL_CYCLES = 390;
  localparam int COUNT_W = 9;
  localparam logic [8:0] REFRESH_PRESET_COUNT = 9'(REFRESH_INTERVAL_CYCLES - 1);
  localparam logic [8:0] COUNT_RESET = 9'h000;
  // -------------------------------------------------------------
  // address decode
  // -------------------------------------------------------------
  localparam logic [7:0] BLOCK_BASE = 8'h00; // a31..a24 of this block
  localparam int OTHER_ACK_W = 6;
  // -------------------------------------------------------------
  // register map
  // -------------------------------------------------------------
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] STATUS_ADDR = 12'h004;
  localparam logic [11:0] COUNT_ADDR = 12'h008;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_ACK_EN_LSB = 8;
  localparam logic [5:0] ACK_EN_RESET = 6'h3f;
  // request carrier from the processor buses
  typedef struct packed {
    logic instr_request;
    logic instr_request_type;
    logic data_request;
    logic data_request_type_hi;
    logic data_request_type_lo;
    logic [7:0] addr_hi;
    logic test_takeover_pin;
  } vrc_bus_req_t;
  // status word, bit 0 first from the right
  typedef struct packed {
    logic instr_burst_acknowledge_delayed;
    logic precharge_second;
    logic precharge_first;
    logic data_sequence_active;
    logic instr_sequence_active;
    logic [2:0] refresh_cycle;
    logic refresh_acknowledge;
    logic refresh_pending;
  } vrc_status_t;
endpackage

// [verification/test_vrc_top.sv]
// testbench for the refresh and access-start block
`timescale 1ns/1ps
`default_nettype none
module test_vrc_top;
  logic clk, rst_n, instr_burst_request, psel, pen, pwr, er, prdy, perr;
  logic ack, ackd, ackc, rack, pend, iseq, dseq, pc1, bus_invalid;
  logic [5:0] other;
  logic [2:0] rc;
  logic [11:0] padr;
  logic [31:0] pwd, prd, rd;
  vrc_pkg::vrc_bus_req_t req;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int t0, t1;
  logic [5:0] walk [7] = '{6'h18, 6'h19, 6'h0b, 6'h0f, 6'h20, 6'h20, 6'h00};
  logic [12:0] bad [10] = '{13'h1100, 13'h1001, 13'h1080, 13'h1400, 13'h1800,
                            13'h0100, 13'h0200, 13'h0040, 13'h0400, 13'h0800};
  vrc_top dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .INSTR_REQUEST_I(req.instr_request),
    .INSTR_REQUEST_TYPE_I(req.instr_request_type), .DATA_REQUEST_I(req.data_request),
    .DATA_REQUEST_TYPE_LO_I(req.data_request_type_lo),
    .DATA_REQUEST_TYPE_HI_I(req.data_request_type_hi), .ADDR_HI_I(req.addr_hi),
    .TEST_TAKEOVER_PIN_I(req.test_takeover_pin), .BUS_INVALID_I(bus_invalid),
    .INSTR_BURST_REQUEST_I(instr_burst_request), .OTHER_BURST_ACK_I(other),
    .INSTR_BURST_ACKNOWLEDGE_O(ack), .INSTR_BURST_ACKNOWLEDGE_DELAYED_O(ackd),
    .BURST_ACK_COMBINED_O(ackc), .REFRESH_ACKNOWLEDGE_O(rack), .REFRESH_PENDING_O(pend),
    .REFRESH_CYCLE_O(rc), .INSTR_SEQUENCE_ACTIVE_O(iseq), .DATA_SEQUENCE_ACTIVE_O(dseq),
    .PRECHARGE_FIRST_O(pc1), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr),
    .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr));
  vrc_cpu_model cpu (.clk_i(clk), .ack_i(ack), .req_o(req), .bus_invalid_o(bus_invalid));
  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // verdict and end of run
  task automatic stop_test();
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    padr <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // wait until no sequence, precharge or refresh is under way
  task automatic wait_idle();
    do begin
      @(posedge clk);
      #1;
    end while ((iseq | dseq | pc1 | rack | pend) !== 1'b0);
  endtask
  task automatic wait_pend(output int t);
    do begin
      @(posedge clk);
      #1;
    end while (pend !== 1'b1);
    t = cyc;
  endtask
  // cycle count with a ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2500) begin
      n_errors++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    {psel, pen, pwr, padr, pwd, instr_burst_request, other} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, vrc_pkg::STATUS_ADDR, 32'h0);
    check("status", rd, 32'h0);
    apb(1'b0, vrc_pkg::CTRL_ADDR, 32'h0);
    check("ctrl", rd, 32'h3f00);
    apb(1'b0, 12'h00c, 32'h0);
    check("unmapped_err", 32'(er), 32'h1);
    check("unmapped_data", rd, 32'h0);
    // each other acknowledge passes only with the registered burst request
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      other <= 6'h01 << i;
      instr_burst_request <= 1'b1;
      @(posedge clk);
      #1;
      check("comb", 32'({ackc, ack}), 32'h2);
      @(posedge clk);
      instr_burst_request <= 1'b0;
      @(posedge clk);
      #1;
      check("comb_off", 32'(ackc), 32'h0);
    end
    apb(1'b1, vrc_pkg::CTRL_ADDR, 32'h0);
    instr_burst_request <= 1'b1;
    other <= 6'h3f;
    @(posedge clk);
    #1;
    check("masked", 32'(ackc), 32'h0);
    wait_pend(t0);
    // counter wrapped at the edge that set pending, so setup samples one
    apb(1'b0, vrc_pkg::COUNT_ADDR, 32'h0);
    check("count", rd, 32'h1);
    check("count_err", 32'(er), 32'h0);
    wait_idle();
    wait_pend(t1);
    check("period", t1 - t0, 32'd390);
    foreach (walk[k]) begin
      @(posedge clk);
      #1;
      check("refresh", 32'({pc1, pend, rack, rc}), 32'(walk[k]));
    end
    // wrong type, address, takeover or bus-invalid: nothing starts
    foreach (bad[k]) begin
      cpu.issue(bad[k][12], bad[k][7:0], bad[k][8], bad[k][9], bad[k][10], bad[k][11]);
      cpu.retire();
      #1;
      check("refused", 32'({iseq, dseq, ack}), 32'h0);
    end
    cpu.issue(1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    cpu.retire();
    #1;
    check("data_access_begin", 32'({dseq, iseq}), 32'h2);
    wait_idle();
    cpu.issue(1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    cpu.retire();
    #1;
    check("instr_access_begin", 32'({iseq, ack}), 32'h2);
    @(posedge clk);
    #1;
    check("back", 32'({ack, ackd, ackc}), 32'h5);
    @(posedge clk);
    #1;
    check("back_d", 32'(ackd), 32'h1);
    repeat (10) @(posedge clk);
    #1;
    check("held", 32'(ack), 32'h1);
    cpu.issue(1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    #1;
    check("drop", 32'({ack, ackc}), 32'h0);
    cpu.retire();
    wait_idle();
    apb(1'b1, vrc_pkg::CTRL_ADDR, 32'h1);
    cpu.issue(1'b1, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    cpu.retire();
    #1;
    check("blocked", 32'({pend, rack, iseq}), 32'h6);
    wait_idle();
    apb(1'b0, vrc_pkg::CTRL_ADDR, 32'h0);
    check("ctrl_force", rd, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire

// [verification/vrc_cpu_model.sv]
// processor model driving the request lines of the memory block
`timescale 1ns/1ps
`default_nettype none
module vrc_cpu_model (
  input wire logic clk_i,
  input wire logic ack_i,
  output var vrc_pkg::vrc_bus_req_t req_o,
  output logic bus_invalid_o
);
  logic ack_q = 1'b0;
  // bus idle at time zero
  initial begin
    req_o = '0;
    bus_invalid_o = 1'b0;
  end
  // place one request on the bus for the coming edge
  task automatic issue(input logic ins, input logic [7:0] a, input logic t,
                       input logic th, input logic tk, input logic bv);
    @(posedge clk_i);
    req_o.instr_request <= ins;
    req_o.data_request <= ~ins;
    req_o.instr_request_type <= t & ins;
    req_o.data_request_type_lo <= t & ~ins;
    req_o.data_request_type_hi <= th;
    req_o.addr_hi <= a;
    req_o.test_takeover_pin <= tk;
    bus_invalid_o <= bv;
  endtask
  // withdraw the strobes after the sampling edge
  task automatic retire();
    @(posedge clk_i);
    req_o.instr_request <= 1'b0;
    req_o.data_request <= 1'b0;
    bus_invalid_o <= 1'b0;
  endtask
  // no address latch in the block: address stays until the acknowledge rises
  always @(posedge clk_i) begin
    ack_q <= ack_i;
    if (ack_i === 1'b1 && ack_q === 1'b0) begin
      req_o.addr_hi <= ~req_o.addr_hi;
    end
  end
endmodule
`default_nettype wire

// [verilog/vrc_refresh_timer.sv]
// refresh interval counter with the pending-request latch
`timescale 1ns/1ps
`default_nettype none
module vrc_refresh_timer (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic force_i,
  input wire logic done_i,
  output logic [8:0] count_o,
  output logic preset_o,
  output logic pending_o
);
  // preset when the last count of the interval is reached
  assign preset_o = (count_o == vrc_pkg::REFRESH_PRESET_COUNT);

  // free-running counter, advances every clock
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= vrc_pkg::COUNT_RESET;
    end else if (preset_o) begin
      count_o <= vrc_pkg::COUNT_RESET;
    end else begin
      count_o <= count_o + 9'h001;
    end
  end

  // pending latch: a new request wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_o <= 1'b0;
    end else begin
      pending_o <= preset_o | force_i | (pending_o & ~done_i);
    end
  end
endmodule
`default_nettype wire

// [verilog/vrc_seq_chain.sv]
// token chain for a fixed-length access or refresh sequence
`timescale 1ns/1ps
`default_nettype none
module vrc_seq_chain #(
  parameter int N = 3
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic start_i,
  input wire logic end_i,
  output logic [N-1:0] q_o
);
  // first stage holds until the end term, later stages shift behind it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= '0;
    end else begin
      q_o[0] <= start_i | (q_o[0] & ~end_i);
      q_o[N-1:1] <= q_o[N-2:0] & {(N-1){~end_i}};
    end
  end
endmodule
`default_nettype wire

// [verilog/vrc_top.sv]
// video-dram refresh sequencer, block select, access start and burst acknowledge
//
// Behaviour
// R1: nine-bit refresh counter advances every clock at 20 MHz.
// R2: counter presets at 389, giving a 390-cycle refresh interval.
// R3: the preset also sets the refresh-pending latch; counting continues.
// R4: pending clears when acknowledge and first refresh cycle are both active.
// R5: refresh spans enough cycles for 120 ns row strobe.
// R6: acknowledge registers active when idle and a refresh is pending.
// R7: acknowledge holds until pending cleared and last refresh cycle active.
// R8: first refresh flag rises after idle, stays for all three cycles.
// R9: second and third flags follow in a chain; third ends refresh.
// R10: instruction select needs request, space type, a31..a24 zero, no takeover.
// R11: data select needs request, both type bits zero, address zero, no takeover.
// R12: the instruction burst acknowledge is only given when this block was selected.
// R13: instruction start only when idle, nothing pending, instruction selected.
// R14: data start uses the same idle qualification with data select.
// R15: burst acknowledge first rises in the second instruction state.
// R16: acknowledge holds by feedback, drops combinationally on a new request.
// R17: combiner ors other acknowledges qualified by registered burst request.
// R18: registered copy of burst acknowledge, one clock late, from its terms.
// R19: instruction and data decode to the same address region.
// R20: bus-invalid inhibits leaving idle on a valid start.
// R21: precharge follows the third cycle of any sequence, two stages.
// R22: processor holds instruction address until burst acknowledge.
`timescale 1ns/1ps
`default_nettype none
module vrc_top (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // processor buses
  input wire logic INSTR_REQUEST_I,
  input wire logic INSTR_REQUEST_TYPE_I,
  input wire logic DATA_REQUEST_I,
  input wire logic DATA_REQUEST_TYPE_LO_I,
  input wire logic DATA_REQUEST_TYPE_HI_I,
  input wire logic [7:0] ADDR_HI_I,
  input wire logic TEST_TAKEOVER_PIN_I,
  input wire logic BUS_INVALID_I,
  input wire logic INSTR_BURST_REQUEST_I,
  input wire logic [5:0] OTHER_BURST_ACK_I,
  output logic INSTR_BURST_ACKNOWLEDGE_O,
  output logic INSTR_BURST_ACKNOWLEDGE_DELAYED_O,
  output logic BURST_ACK_COMBINED_O,
  output logic REFRESH_ACKNOWLEDGE_O,
  output logic REFRESH_PENDING_O,
  output logic [2:0] REFRESH_CYCLE_O,
  output logic INSTR_SEQUENCE_ACTIVE_O,
  output logic DATA_SEQUENCE_ACTIVE_O,
  output logic PRECHARGE_FIRST_O,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // -------------------------------------------------------------
  // declarations
  // -------------------------------------------------------------
  vrc_pkg::vrc_bus_req_t req;
  vrc_pkg::vrc_status_t status;
  logic [8:0] refresh_interval_count;
  logic preset;
  logic refresh_pending;
  logic refresh_acknowledge_q;
  logic [vrc_pkg::REFRESH_SEQ_CYCLES-1:0] refresh_cycle;
  logic refresh_cycle_first;
  logic refresh_cycle_last;
  logic [vrc_pkg::INSTR_SEQ_STAGES-1:0] iseq_q;
  logic [vrc_pkg::DATA_SEQ_STAGES-1:0] dseq;
  logic instr_sequence_active;
  logic instr_sequence_second;
  logic data_sequence_active;
  logic iseq_end;
  logic precharge_first_q;
  logic precharge_second_q;
  logic instr_block_select;
  logic data_block_select;
  logic idle_no_refresh;
  logic instr_access_begin;
  logic data_access_begin;
  logic instr_burst_acknowledge;
  logic instr_burst_acknowledge_delayed_q;
  logic instr_burst_request_registered_q;
  logic force_refresh;
  logic [5:0] ack_enable_q;
  logic apb_write;
  logic apb_setup;
  logic apb_mapped;

  // -------------------------------------------------------------
  // request decode
  // -------------------------------------------------------------
  // gather the processor request lines
  assign req = '{instr_request: INSTR_REQUEST_I,
                 instr_request_type: INSTR_REQUEST_TYPE_I,
                 data_request: DATA_REQUEST_I,
                 data_request_type_hi: DATA_REQUEST_TYPE_HI_I,
                 data_request_type_lo: DATA_REQUEST_TYPE_LO_I,
                 addr_hi: ADDR_HI_I,
                 test_takeover_pin: TEST_TAKEOVER_PIN_I};

  // both ports share one array, so both compare against one base
  assign instr_block_select = req.instr_request & ~req.instr_request_type // R10
                              & (req.addr_hi == vrc_pkg::BLOCK_BASE) // R19
                              & ~req.test_takeover_pin;
  assign data_block_select = req.data_request // R11
                             & ~req.data_request_type_hi & ~req.data_request_type_lo
                             & (req.addr_hi == vrc_pkg::BLOCK_BASE) // R19
                             & ~req.test_takeover_pin;

  // start only from idle with no refresh pending or starting
  assign idle_no_refresh = ~instr_sequence_active & ~data_sequence_active
                           & ~refresh_acknowledge_q & ~precharge_first_q & ~refresh_pending;
  assign instr_access_begin = idle_no_refresh & instr_block_select; // R13
  assign data_access_begin = idle_no_refresh & data_block_select; // R14

  // -------------------------------------------------------------
  // refresh interval and request
  // -------------------------------------------------------------
  // counter plus pending latch
  vrc_refresh_timer u_timer (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .force_i(force_refresh),
    .done_i(refresh_acknowledge_q & refresh_cycle_first), // R4
    .count_o(refresh_interval_count), // R1
    .preset_o(preset), // R2
    .pending_o(refresh_pending) // R3
  );

  // acknowledge sets from idle and holds until the request is served
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      refresh_acknowledge_q <= 1'b0;
    end else begin
      refresh_acknowledge_q <= (~data_sequence_active & ~instr_sequence_active
                                & refresh_pending) // R6
                               | (refresh_acknowledge_q
                                  & ~(~refresh_pending & refresh_cycle_last)); // R7
    end
  end

  // three refresh cycles keep the row strobe up for its least time
  vrc_seq_chain #(
    .N(vrc_pkg::REFRESH_SEQ_CYCLES) // R5
  ) u_refresh_chain (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .start_i(~refresh_cycle_first & ~precharge_first_q & refresh_acknowledge_q), // R8
    .end_i(refresh_cycle_last), // R9
    .q_o(refresh_cycle)
  );
  assign refresh_cycle_first = refresh_cycle[0];
  assign refresh_cycle_last = refresh_cycle[vrc_pkg::REFRESH_SEQ_CYCLES-1];

  // -------------------------------------------------------------
  // access sequences and precharge
  // -------------------------------------------------------------
  // instruction token: fifth cycle is stage three off, stage four on
  assign iseq_end = ~iseq_q[2] & iseq_q[3];
  assign instr_sequence_active = iseq_q[0];
  assign instr_sequence_second = iseq_q[1];

  // instruction sequence, bus-invalid holds it in idle
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      iseq_q <= '0;
    end else begin
      iseq_q[0] <= (~BUS_INVALID_I & ~iseq_q[0] & instr_access_begin) // R20
                   | (iseq_q[0] & ~iseq_end);
      iseq_q[1] <= iseq_q[0] & ~iseq_end;
      iseq_q[2] <= iseq_q[1] & ~iseq_q[3];
      iseq_q[3] <= iseq_q[2];
    end
  end

  // data sequence, four stages
  vrc_seq_chain #(
    .N(vrc_pkg::DATA_SEQ_STAGES)
  ) u_data_chain (
    .clk_i(CORE_CLK_I),
    .rst_n_i(RST_N_I),
    .start_i(~BUS_INVALID_I & ~dseq[0] & data_access_begin), // R20
    .end_i(dseq[vrc_pkg::DATA_SEQ_STAGES-1]),
    .q_o(dseq)
  );
  assign data_sequence_active = dseq[0];

  // precharge after the third cycle of any sequence
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      precharge_first_q <= 1'b0;
      precharge_second_q <= 1'b0;
    end else begin
      precharge_first_q <= (~precharge_first_q
                            & (iseq_q[2] | dseq[2] | refresh_cycle_last)) // R21
                           | (precharge_first_q & ~precharge_second_q);
      precharge_second_q <= precharge_first_q; // R21
    end
  end

  // -------------------------------------------------------------
  // burst acknowledge
  // -------------------------------------------------------------
  // raised only by our own instruction sequence, held until a new request
  assign instr_burst_acknowledge = instr_sequence_second // R15 R12
                                   | (~req.instr_request
                                      & instr_burst_acknowledge_delayed_q); // R16

  // delayed copy built from the same terms, and the burst request register
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      instr_burst_acknowledge_delayed_q <= 1'b0;
      instr_burst_request_registered_q <= 1'b0;
    end else begin
      instr_burst_acknowledge_delayed_q <= instr_sequence_second
                                           | (~req.instr_request
                                              & instr_burst_acknowledge_delayed_q); // R18
      instr_burst_request_registered_q <= INSTR_BURST_REQUEST_I;
    end
  end

  // combinational response outputs
  assign INSTR_BURST_ACKNOWLEDGE_O = instr_burst_acknowledge;
  assign BURST_ACK_COMBINED_O = ((|(OTHER_BURST_ACK_I & ack_enable_q)) // R17
                                 & instr_burst_request_registered_q)
                                | (instr_sequence_second & instr_burst_request_registered_q)
                                | (~req.instr_request & instr_burst_acknowledge_delayed_q);

  // state outputs, all straight from flops
  assign INSTR_BURST_ACKNOWLEDGE_DELAYED_O = instr_burst_acknowledge_delayed_q;
  assign REFRESH_ACKNOWLEDGE_O = refresh_acknowledge_q;
  assign REFRESH_PENDING_O = refresh_pending;
  assign REFRESH_CYCLE_O = refresh_cycle;
  assign INSTR_SEQUENCE_ACTIVE_O = instr_sequence_active;
  assign DATA_SEQUENCE_ACTIVE_O = data_sequence_active;
  assign PRECHARGE_FIRST_O = precharge_first_q;

  // -------------------------------------------------------------
  // apb register slave
  // -------------------------------------------------------------
  assign apb_setup = PSEL & ~PENABLE;
  assign apb_write = PSEL & PENABLE & PREADY & PWRITE;
  assign apb_mapped = (PADDR == vrc_pkg::CTRL_ADDR) | (PADDR == vrc_pkg::STATUS_ADDR)
                      | (PADDR == vrc_pkg::COUNT_ADDR);
  assign force_refresh = apb_write & (PADDR == vrc_pkg::CTRL_ADDR)
                         & PWDATA[vrc_pkg::CTRL_FORCE_BIT];
  assign status = '{instr_burst_acknowledge_delayed: instr_burst_acknowledge_delayed_q,
                    precharge_second: precharge_second_q,
                    precharge_first: precharge_first_q,
                    data_sequence_active: data_sequence_active,
                    instr_sequence_active: instr_sequence_active,
                    refresh_cycle: refresh_cycle,
                    refresh_acknowledge: refresh_acknowledge_q,
                    refresh_pending: refresh_pending};

  // enable mask for the other devices' acknowledges
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_enable_q <= vrc_pkg::ACK_EN_RESET;
    end else if (apb_write & (PADDR == vrc_pkg::CTRL_ADDR)) begin
      ack_enable_q <= PWDATA[vrc_pkg::CTRL_ACK_EN_LSB +: 6];
    end
  end

  // answer one cycle after setup: ready, read data and error together
  always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end else begin
      PREADY <= apb_setup;
      PSLVERR <= apb_setup & ~apb_mapped;
      if (apb_setup & ~PWRITE & (PADDR == vrc_pkg::CTRL_ADDR)) begin
        PRDATA <= {18'h00000, ack_enable_q, 8'h00};
      end else if (apb_setup & ~PWRITE & (PADDR == vrc_pkg::STATUS_ADDR)) begin
        PRDATA <= {22'h000000, status};
      end else if (apb_setup & ~PWRITE & (PADDR == vrc_pkg::COUNT_ADDR)) begin
        PRDATA <= {23'h000000, refresh_interval_count};
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  count_wrap_a: assert property (preset |=> refresh_interval_count == 9'h000) // R2
    else $error("refresh counter did not wrap after 389");
  count_step_a: assert property (!preset |=> refresh_interval_count // R1
                                  == $past(refresh_interval_count) + 9'h001)
    else $error("refresh counter did not advance");
  pend_set_a: assert property (preset |=> refresh_pending) // R3
    else $error("preset did not set pending");
  pend_clear_a: assert property (refresh_acknowledge_q && refresh_cycle_first // R4
                                 && !preset && !force_refresh |=> !refresh_pending)
    else $error("pending not cleared after refresh");
  ack_set_a: assert property (!instr_sequence_active && !data_sequence_active // R6
                              && refresh_pending |=> refresh_acknowledge_q)
    else $error("refresh acknowledge missing");
  ack_hold_a: assert property (refresh_acknowledge_q // R7
                               && !(!refresh_pending && refresh_cycle_last)
                               |=> refresh_acknowledge_q)
    else $error("refresh acknowledge dropped early");
  refresh_chain_a: assert property ($rose(refresh_cycle_first) |-> // R8
                                    !refresh_cycle[1] ##1 refresh_cycle[1] && refresh_cycle_first
                                    ##1 refresh_cycle_last && refresh_cycle_first
                                    ##1 !refresh_cycle_first)
    else $error("refresh sequence not three cycles");
  refresh_start_a: assert property ($rose(refresh_cycle_first) |-> // R8
                                    $past(refresh_acknowledge_q) && !$past(precharge_first_q))
    else $error("refresh started without acknowledge");
  instr_sel_a: assert property ($rose(instr_sequence_active) |-> $past(INSTR_REQUEST_I) // R10
                                && $past(ADDR_HI_I) == 8'h00 && !$past(TEST_TAKEOVER_PIN_I)
                                && !$past(INSTR_REQUEST_TYPE_I))
    else $error("instruction select on foreign address");
  instr_start_a: assert property ($rose(instr_sequence_active) |-> // R13
                                  $past(instr_block_select) && !$past(refresh_pending)
                                  && !$past(BUS_INVALID_I))
    else $error("instruction sequence started illegally");
  data_start_a: assert property ($rose(data_sequence_active) |-> // R14
                                 $past(data_block_select) && !$past(refresh_acknowledge_q)
                                 && !$past(BUS_INVALID_I))
    else $error("data sequence started illegally");
  back_first_a: assert property ($rose(instr_sequence_active) |-> // R15
                                 !instr_burst_acknowledge ##1 instr_burst_acknowledge)
    else $error("burst acknowledge not in second state");
  back_drop_a: assert property (INSTR_REQUEST_I && !instr_sequence_second // R16
                                |-> !instr_burst_acknowledge)
    else $error("burst acknowledge held through new request");
  back_delay_a: assert property (instr_burst_acknowledge // R18
                                 |=> instr_burst_acknowledge_delayed_q)
    else $error("delayed acknowledge missing");
  precharge_a: assert property ($rose(precharge_first_q) |-> // R21
                                $past(iseq_q[2] || dseq[2] || refresh_cycle_last)
                                ##1 precharge_second_q)
    else $error("precharge out of place");

  refresh_done_c: cover property (refresh_acknowledge_q && refresh_cycle_last);
  instr_run_c: cover property ($rose(instr_sequence_active) ##[1:8] instr_burst_acknowledge);
  data_run_c: cover property ($rose(data_sequence_active));
  blocked_c: cover property (instr_block_select && refresh_pending);
endmodule
`default_nettype wire
